// ==== oscs_consts.svh ====
// Behaviour
// - with oversampling, the next convert-start rising edge takes every channel's first sample.
// - remaining burst samples use an internal sampling strobe, no further convert-start edges.
// - busy stays high longer as the oversampling ratio rises.
// - previous results stay readable while busy is high.
// - result registers load new data when busy falls.
// - ratio select pins are captured on busy falling, governing the next conversion.
// - select 000 none, 001..110 ratios 2..64, 111 invalid.
`ifndef OSCS_CONSTS_SVH
`define OSCS_CONSTS_SVH
`define OSCS_SEL_NONE 3'h0
`define OSCS_SEL_INVALID 3'h7
`define OSCS_SEL_RESET 3'h0
`define OSCS_MAX_SHIFT 6
`define OSCS_CONV_TIME_NS 4000
`define OSCS_CLK_NS 20
`define OSCS_CONV_CYCLES ((`OSCS_CONV_TIME_NS + `OSCS_CLK_NS - 1) / `OSCS_CLK_NS)
`endif

// ==== oscs_pkg.sv ====
package oscs_pkg;
  typedef enum logic [1:0] {OSCS_IDLE, OSCS_CONVERT, OSCS_DONE} oscs_state_t;
endpackage : oscs_pkg

// ==== oscs_sequencer.sv ====
`timescale 1ns/1ps
`include "oscs_consts.svh"
module oscs_sequencer #(
  parameter int CHANNELS = 8,
  parameter int SAMPLE_W = 14,
  parameter int CONV_CYCLES = `OSCS_CONV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic convert_start_group_a_i,
  input wire logic convert_start_group_b_i,
  input wire logic [2:0] oversample_ratio_select_i,
  input wire logic [CHANNELS*SAMPLE_W-1:0] sample_data_i,
  output logic sample_strobe_o,
  output logic busy_o,
  output logic [CHANNELS*SAMPLE_W-1:0] result_o,
  output logic result_update_o
);
  import oscs_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  // sum of up to 2**max_shift samples needs max_shift guard bits
  localparam int ACC_W = SAMPLE_W + `OSCS_MAX_SHIFT;
  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam int SLW = `OSCS_MAX_SHIFT + 1;
  localparam logic [CNT_W-1:0] SLOT_LOAD = CNT_W'(CONV_CYCLES);
  localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(1);
  localparam logic [SLW-1:0] ONE_SAMPLE = SLW'(1);

  typedef struct packed {
    // pin synchronisers
    logic [1:0] cs_a_sync;
    logic [1:0] cs_b_sync;
    logic cs_prev;
    logic [2:0] os_pin_sync0;
    logic [2:0] os_pin_sync1;

    // sequencing
    logic [2:0] os_sel;
    oscs_state_t state;
    logic [CNT_W-1:0] conv_cnt;
    logic [SLW-1:0] samples_left;
    logic strobe;
    logic busy;
    logic upd;

    // datapath
    logic [CHANNELS-1:0][ACC_W-1:0] acc;
    logic [CHANNELS*SAMPLE_W-1:0] result;
  } oscs_regs_t;

  oscs_regs_t q_r;
  oscs_regs_t q_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // invalid code runs as no oversampling: a safe fallback, never hangs
  function automatic logic [2:0] ratio_shift(input logic [2:0] sel);
    if (sel == `OSCS_SEL_INVALID)
    begin
      ratio_shift = `OSCS_SEL_NONE;
    end
    else
    begin
      ratio_shift = sel;
    end
  endfunction : ratio_shift

  // samples in one burst, one when oversampling is off
  function automatic logic [SLW-1:0] burst_len(input logic [2:0] sel);
    burst_len = ONE_SAMPLE << ratio_shift(sel);
  endfunction : burst_len

  // ----------------------------------------
  // start detect
  // ----------------------------------------
  logic cs_any;
  logic cs_rise;

  // both groups must be high: a lone group never starts a burst
  assign cs_any = q_r.cs_a_sync[1] & q_r.cs_b_sync[1];
  assign cs_rise = cs_any & ~q_r.cs_prev;

  // ----------------------------------------
  // slot timing
  // ----------------------------------------
  logic slot_end;
  logic last_sample;

  // one conversion slot per sample: busy grows with the ratio
  assign slot_end = (q_r.conv_cnt <= SLOT_LAST);
  assign last_sample = (q_r.samples_left == ONE_SAMPLE);

  // ----------------------------------------
  // per channel arithmetic
  // ----------------------------------------
  logic [CHANNELS-1:0][ACC_W-1:0] acc_sum;
  logic [CHANNELS-1:0][SAMPLE_W-1:0] avg_val;

  genvar ch;

  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      logic signed [SAMPLE_W-1:0] raw;
      logic signed [ACC_W-1:0] raw_ext;
      logic signed [ACC_W-1:0] scaled;

      assign raw = sample_data_i[ch*SAMPLE_W +: SAMPLE_W];
      // sign extension keeps negative samples negative in the sum
      assign raw_ext = ACC_W'(raw);
      assign acc_sum[ch] = q_r.acc[ch] + raw_ext;

      // arithmetic shift keeps sign; truncating average of the burst
      assign scaled = $signed(q_r.acc[ch]) >>> ratio_shift(q_r.os_sel);
      assign avg_val[ch] = scaled[SAMPLE_W-1:0];
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    q_nxt = q_r;

    q_nxt.cs_a_sync = {q_r.cs_a_sync[0], convert_start_group_a_i};
    q_nxt.cs_b_sync = {q_r.cs_b_sync[0], convert_start_group_b_i};
    q_nxt.cs_prev = cs_any;

    q_nxt.os_pin_sync0 = oversample_ratio_select_i;
    q_nxt.os_pin_sync1 = q_r.os_pin_sync0;

    q_nxt.strobe = 1'h0;
    q_nxt.upd = 1'h0;

    unique case (q_r.state)
      OSCS_IDLE:
      begin
        // edges while busy are ignored: only idle takes a start
        if (cs_rise)
        begin
          q_nxt.state = OSCS_CONVERT;
          q_nxt.busy = 1'h1;
          q_nxt.strobe = 1'h1;
          q_nxt.samples_left = burst_len(q_r.os_sel);
          q_nxt.conv_cnt = SLOT_LOAD;
          q_nxt.acc = '0;
        end
      end

      OSCS_CONVERT:
      begin
        if (!slot_end)
        begin
          q_nxt.conv_cnt = q_r.conv_cnt - SLOT_LAST;
        end
        else
        begin
          q_nxt.acc = acc_sum;
          q_nxt.samples_left = q_r.samples_left - ONE_SAMPLE;
          q_nxt.conv_cnt = SLOT_LOAD;
          if (last_sample)
          begin
            q_nxt.state = OSCS_DONE;
          end
          else
          begin
            q_nxt.strobe = 1'h1;
          end
        end
      end

      OSCS_DONE:
      begin
        q_nxt.state = OSCS_IDLE;
        q_nxt.busy = 1'h0;
        q_nxt.upd = 1'h1;
        q_nxt.os_sel = q_r.os_pin_sync1;
        q_nxt.result = avg_val;
      end

      default:
      begin
        q_nxt.state = OSCS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
      q_r.os_sel <= `OSCS_SEL_RESET;
      q_r.state <= OSCS_IDLE;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // results hold steady during busy so reads can overlap conversion
  assign result_o = q_r.result;

  assign busy_o = q_r.busy;

  assign sample_strobe_o = q_r.strobe;

  assign result_update_o = q_r.upd;
endmodule : oscs_sequencer

// ==== oscs_host_model.sv ====
`timescale 1ns/1ps
module oscs_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic busy_i,
  output logic start_o
);
  // one start for both groups, raised only once busy is low
  always_ff @(posedge clk_i) start_o <= go_i && !busy_i;
endmodule : oscs_host_model

// ==== oscs_sequencer_sva.sv ====
`timescale 1ns/1ps
module oscs_sequencer_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_strobe_o,
  input wire logic busy_o,
  input wire logic [111:0] result_o,
  input wire logic result_update_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  upd_on_fall_a: assert property (result_update_o == $fell(busy_o)) else $error("upd");
  res_hold_a: assert property (!result_update_o |-> $stable(result_o)) else $error("res");
  upd_once_a: assert property (result_update_o |=> !result_update_o) else $error("once");
  first_strobe_a: assert property ($rose(busy_o) |-> sample_strobe_o) else $error("first");
  idle_strobe_a: assert property (!busy_o |-> !sample_strobe_o) else $error("idle");
  strobe_gap_a: assert property (sample_strobe_o |=> !sample_strobe_o [*2]) else $error("gap");
  busy_min_a: assert property ($rose(busy_o) |-> busy_o [*4]) else $error("min");
  busy_tail_a: assert property ($fell(busy_o) |-> !$past(sample_strobe_o)) else $error("tail");
  cover property ($rose(busy_o));
  cover property (result_update_o);
  cover property (sample_strobe_o && !$rose(busy_o));
endmodule : oscs_sequencer_sva
bind oscs_sequencer oscs_sequencer_sva oscs_sequencer_sva_i (.clk_i(clk_i), .rst_i(rst_i),
  .sample_strobe_o(sample_strobe_o), .busy_o(busy_o), .result_o(result_o),
  .result_update_o(result_update_o));

// ==== oscs_sequencer_bench.sv ====
`timescale 1ns/1ps
module oscs_sequencer_bench;
  logic clk_i = 0, rst_i = 1, go = 0, flag = 0, st, stb, bz, upd;
  logic [2:0] sel = 3'h0;
  logic [111:0] res;
  int error_cnt = 0, check_count = 0;
  initial forever #10 clk_i = ~clk_i;
  // alternate samples per slot so the average differs from either value
  always @(posedge clk_i) flag <= bz & (flag ^ stb);
  oscs_host_model oscs_host_model_i (.clk_i(clk_i), .go_i(go), .busy_i(bz), .start_o(st));
  oscs_sequencer #(.CONV_CYCLES(3)) oscs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
    .convert_start_group_a_i(st), .convert_start_group_b_i(st),
    .oversample_ratio_select_i(sel), .sample_data_i({8{flag ? 14'h6 : 14'h4}}),
    .sample_strobe_o(stb), .busy_o(bz), .result_o(res), .result_update_o(upd));
  task chk(input logic [111:0] got, input logic [111:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic convert(input int n, input logic [2:0] nxt);
    int b = 1, s = 0, k = 0, u = 0, m = 0;
    logic [111:0] r0;
    @(posedge clk_i);
    sel <= nxt;
    go <= 1;
    while (!bz && k++ < 50) @(negedge clk_i);
    s = stb;
    r0 = res;
    @(posedge clk_i) go <= 0;
    do
    begin
      @(negedge clk_i);
      s += stb;
      u += upd;
      m += (bz && res !== r0);
    end while (bz && ++b < 999);
    chk(res, {8{n == 1 ? 14'h6 : 14'h5}});
    chk(112'(u), 112'(1));
    chk(112'(m), 112'(0));
    chk(112'(b), 112'(n * 3 + 1));
    chk(112'(s), 112'(n));
  endtask : convert
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    // pins set now act on the next conversion, so the ratio lags one step
    for (int i = 1; i < 9; i++) convert((i == 1 || i == 8) ? 1 : 1 << (i - 1), 3'(i));
    give_verdict;
  end
  initial
  begin
    #50us;
    error_cnt++;
    give_verdict;
  end
endmodule : oscs_sequencer_bench
